// ===== src/ccc_chan_cfg.sv
// Function
// - Receive source bit resets to one
// - Source one: reference loads outputs, drives clock
// - Source zero: recovered clock loads, drives clock
// - Receive rate bit resets to one
// - Rate one, recovered source: half-rate pair
// - Rate zero, recovered source: full-rate pair
// - Rate one, full-rate reference: half-rate pair
// - Rate zero, full-rate reference: full-rate pair
// - Half-rate reference ignores rate, half-rate pair
// - Primary detect field resets 10; 00 disables
// - Primary codes select 140, 280, 420 mV
// - Secondary detect field same as primary
// - Encoder bit resets one; zero sends raw
// - Transmit clock select resets to one
// - Select one: reference rise captures, buffer bypassed
// - Select zero: host clock rise captures
// - Select one, pll rate one: both edges
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ccc_chan_cfg #(
	parameter int NCH = ccc_pkg::NCH
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Classic Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Link pins, all asynchronous to clk_sys
	input wire logic [NCH-1:0] channel_reference_clock,
	input wire logic [NCH-1:0] ref_clock_half_rate,
	input wire logic [NCH-1:0] recovered_byte_clock,
	input wire logic [NCH-1:0] tx_host_input_clock,
	input wire logic [NCH-1:0][ccc_pkg::CHAR_W-1:0] rx_char_in,
	input wire logic [NCH-1:0][ccc_pkg::TXD_W-1:0] tx_char_data_in,
	input wire logic [NCH-1:0][ccc_pkg::TXC_W-1:0] tx_char_control_in,
	// Receive side outputs
	output logic [NCH-1:0] rx_clock_out_pair_p,
	output logic [NCH-1:0] rx_clock_out_pair_n,
	output logic [NCH-1:0][ccc_pkg::CHAR_W-1:0] rx_char_out,
	// Transmit side outputs
	output logic [NCH-1:0][ccc_pkg::CHAR_W-1:0] tx_char_out,
	output logic [NCH-1:0] tx_char_valid,
	output logic [NCH-1:0] tx_encoder_enable,
	output logic [NCH-1:0] tx_phase_align_bypass,
	// Signal detector controls
	output logic [NCH-1:0] primary_detect_enable,
	output logic [NCH-1:0][ccc_pkg::THR_W-1:0] primary_detect_threshold_mv,
	output logic [NCH-1:0] secondary_detect_enable,
	output logic [NCH-1:0][ccc_pkg::THR_W-1:0] secondary_detect_threshold_mv
);

	// Widths of the two sampled pin groups
	localparam int CLK_W = 3 * NCH;
	localparam int DAT_W = NCH * (ccc_pkg::CHAR_W + ccc_pkg::TXD_W + ccc_pkg::TXC_W + 1);

	// Threshold decode, used for both detectors
	function automatic logic [ccc_pkg::THR_W-1:0] det_threshold(input logic [1:0] code);
		logic [ccc_pkg::THR_W-1:0] mv;
		mv = '0;
		case (code)
			ccc_pkg::DET_LOW: mv = ccc_pkg::THR_LOW_MV;
			ccc_pkg::DET_MID: mv = ccc_pkg::THR_MID_MV;
			ccc_pkg::DET_HIGH: mv = ccc_pkg::THR_HIGH_MV;
			default: mv = '0; // Detector off
		endcase
		return mv;
	endfunction : det_threshold

	// Channel index from a config register offset; -1 when not a config offset
	function automatic int cfg_index(input logic [7:0] adr);
		int idx;
		idx = -1;
		case (adr)
			ccc_pkg::OFS_CFG0: idx = 0;
			ccc_pkg::OFS_CFG1: idx = 1;
			ccc_pkg::OFS_CFG2: idx = 2;
			ccc_pkg::OFS_CFG3: idx = 3;
			default: idx = -1;
		endcase
		return idx;
	endfunction : cfg_index

	// Sampled pins
	ccc_sync_if #(.W(CLK_W)) clk_s ();
	ccc_sync_if #(.W(DAT_W)) dat_s ();

	// Clock pins: reference, recovered, host transmit clock
	ccc_link_sync #(.W(CLK_W)) u_clk_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d({tx_host_input_clock, recovered_byte_clock, channel_reference_clock}),
		.o(clk_s)
	);

	// Data pins pass the same two stages so they line up with the clock edges
	ccc_link_sync #(.W(DAT_W)) u_dat_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d({ref_clock_half_rate, tx_char_control_in, tx_char_data_in, rx_char_in}),
		.o(dat_s)
	);

	// Unpacked views of the synchronised pins
	logic [NCH-1:0] ref_lvl, ref_rise, ref_fall, rec_lvl, rec_rise, host_rise, ref_half;
	logic [NCH-1:0][ccc_pkg::CHAR_W-1:0] rx_char_s;
	logic [NCH-1:0][ccc_pkg::TXD_W-1:0] txd_s;
	logic [NCH-1:0][ccc_pkg::TXC_W-1:0] txc_s;
	assign ref_lvl = clk_s.level[NCH-1:0];
	assign ref_rise = clk_s.rise[NCH-1:0];
	assign ref_fall = clk_s.fall[NCH-1:0];
	assign rec_lvl = clk_s.level[2*NCH-1:NCH];
	assign rec_rise = clk_s.rise[2*NCH-1:NCH];
	assign host_rise = clk_s.rise[3*NCH-1:2*NCH];
	assign {ref_half, txc_s, txd_s, rx_char_s} = dat_s.level;

	// Receive clock selection per channel; declared here because the status read uses them
	logic [NCH-1:0] rx_src_ref; // Reference is the source
	logic [NCH-1:0] rx_divide; // Output runs at half the selected clock
	logic [NCH-1:0] rx_src_lvl; // Level of the selected clock
	logic [NCH-1:0] rx_load; // Edge on which the output register loads
	logic [NCH-1:0] rx_p, rx_n;
	logic [NCH-1:0] next_rx_p, next_rx_n;
	logic [NCH-1:0][ccc_pkg::CHAR_W-1:0] rx_q;
	logic [NCH-1:0][ccc_pkg::CHAR_W-1:0] next_rx_q;

	// Per-channel configuration, one word each
	logic [NCH-1:0][ccc_pkg::CFG_W-1:0] cfg;
	logic [NCH-1:0][ccc_pkg::CFG_W-1:0] next_cfg;
	logic wb_ack;
	logic next_wb_ack;
	logic [31:0] wb_rdat;
	logic [31:0] next_wb_rdat;

	// Bus slave: answer one cycle after the request, drop ack the cycle after
	always_comb begin
		int idx;
		logic [31:0] merged;
		idx = cfg_index(wb_adr_i);
		merged = '0;
		next_cfg = cfg;
		next_wb_ack = wb_cyc_i & wb_stb_i & ~wb_ack;
		next_wb_rdat = '0;
		if (wb_cyc_i && wb_stb_i && !wb_ack) begin
			if (idx >= 0) begin
				// Only the addressed channel changes
				merged = {23'h000000, cfg[idx]};
				next_wb_rdat = merged;
				if (wb_we_i) begin
					for (int b = 0; b < 2; b++) begin
						if (wb_sel_i[b]) begin
							merged[8*b +: 8] = wb_dat_i[8*b +: 8];
						end
					end
					next_cfg[idx] = merged[ccc_pkg::CFG_W-1:0];
				end
			end else if (wb_adr_i == ccc_pkg::OFS_STATUS) begin
				// Read-only view of the live channel state; writes ignored
				for (int c = 0; c < NCH; c++) begin
					next_wb_rdat[ccc_pkg::ST_W*c + ccc_pkg::ST_DIVIDE] = rx_divide[c];
					next_wb_rdat[ccc_pkg::ST_W*c + ccc_pkg::ST_RXCLK] = rx_clock_out_pair_p[c];
					next_wb_rdat[ccc_pkg::ST_W*c + ccc_pkg::ST_REF_HALF] = ref_half[c];
					next_wb_rdat[ccc_pkg::ST_W*c + ccc_pkg::ST_TX_SEL] =
						cfg[c][ccc_pkg::F_TX_SEL];
				end
			end
			// Unmapped offsets still ack and read as zero
		end
	end

	// Bus registers; every channel comes up with the documented defaults
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cfg <= {NCH{ccc_pkg::CFG_RESET}};
			wb_ack <= 1'b0;
			wb_rdat <= '0;
		end else begin
			cfg <= next_cfg;
			wb_ack <= next_wb_ack;
			wb_rdat <= next_wb_rdat;
		end
	end
	assign wb_ack_o = wb_ack;
	assign wb_dat_o = wb_rdat;

	// A half-rate reference already is half character rate, so the rate bit is moot
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			rx_src_ref[c] = cfg[c][ccc_pkg::F_RX_SRC];
			rx_src_lvl[c] = rx_src_ref[c] ? ref_lvl[c] : rec_lvl[c];
			rx_divide[c] = cfg[c][ccc_pkg::F_RX_RATE] & ~(rx_src_ref[c] & ref_half[c]);
			if (rx_src_ref[c]) begin
				// Half-rate reference carries a character on each edge
				rx_load[c] = ref_half[c] ? (ref_rise[c] | ref_fall[c]) : ref_rise[c];
			end else begin
				rx_load[c] = rec_rise[c];
			end
		end
	end

	// Receive clock pair and output register next values
	always_comb begin
		next_rx_p = rx_p;
		next_rx_q = rx_q;
		for (int c = 0; c < NCH; c++) begin
			if (rx_divide[c]) begin
				// Toggle once per character so host latches on alternate edges
				if (rx_load[c]) begin
					next_rx_p[c] = ~rx_p[c];
				end
			end else begin
				next_rx_p[c] = rx_src_lvl[c];
			end
			if (rx_load[c]) begin
				next_rx_q[c] = rx_char_s[c];
			end
		end
		next_rx_n = ~next_rx_p; // Complement always tracks the true output
	end

	// Receive registers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rx_p <= '0;
			rx_n <= '1;
			rx_q <= '0;
		end else begin
			rx_p <= next_rx_p;
			rx_n <= next_rx_n;
			rx_q <= next_rx_q;
		end
	end
	assign rx_clock_out_pair_p = rx_p;
	assign rx_clock_out_pair_n = rx_n;
	assign rx_char_out = rx_q;

	// Transmit capture and static control outputs
	logic [NCH-1:0] tx_cap;
	logic [NCH-1:0][ccc_pkg::CHAR_W-1:0] tx_q, next_tx_q;
	logic [NCH-1:0] tx_v, next_tx_v;
	logic [NCH-1:0] enc_q, next_enc_q, byp_q, next_byp_q;
	logic [NCH-1:0] pri_en, next_pri_en, sec_en, next_sec_en;
	logic [NCH-1:0][ccc_pkg::THR_W-1:0] pri_mv, next_pri_mv, sec_mv, next_sec_mv;

	// Choose the capture edge and decode the per-channel controls
	always_comb begin
		logic [1:0] pri_code;
		logic [1:0] sec_code;
		pri_code = '0;
		sec_code = '0;
		next_tx_q = tx_q;
		for (int c = 0; c < NCH; c++) begin
			if (cfg[c][ccc_pkg::F_TX_SEL]) begin
				// Reference edge; both edges when the pll doubles the rate
				tx_cap[c] = ref_rise[c] |
					(cfg[c][ccc_pkg::F_TX_RATE] & ref_fall[c]);
			end else begin
				tx_cap[c] = host_rise[c];
			end
			if (tx_cap[c]) begin
				next_tx_q[c] = {txc_s[c], txd_s[c]};
			end
			next_tx_v[c] = tx_cap[c];
			next_byp_q[c] = cfg[c][ccc_pkg::F_TX_SEL];
			next_enc_q[c] = cfg[c][ccc_pkg::F_ENC];
			pri_code = cfg[c][ccc_pkg::F_PRI_LO +: 2];
			sec_code = cfg[c][ccc_pkg::F_SEC_LO +: 2];
			next_pri_en[c] = (pri_code != ccc_pkg::DET_OFF);
			next_sec_en[c] = (sec_code != ccc_pkg::DET_OFF);
			next_pri_mv[c] = det_threshold(pri_code);
			next_sec_mv[c] = det_threshold(sec_code);
		end
	end

	// Transmit and detector registers; reset values match the default settings
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tx_q <= '0;
			tx_v <= '0;
			enc_q <= '1;
			byp_q <= '1;
			pri_en <= '1;
			sec_en <= '1;
			pri_mv <= {NCH{ccc_pkg::THR_MID_MV}};
			sec_mv <= {NCH{ccc_pkg::THR_MID_MV}};
		end else begin
			tx_q <= next_tx_q;
			tx_v <= next_tx_v;
			enc_q <= next_enc_q;
			byp_q <= next_byp_q;
			pri_en <= next_pri_en;
			sec_en <= next_sec_en;
			pri_mv <= next_pri_mv;
			sec_mv <= next_sec_mv;
		end
	end
	assign tx_char_out = tx_q;
	assign tx_char_valid = tx_v;
	assign tx_encoder_enable = enc_q;
	assign tx_phase_align_bypass = byp_q;
	assign primary_detect_enable = pri_en;
	assign secondary_detect_enable = sec_en;
	assign primary_detect_threshold_mv = pri_mv;
	assign secondary_detect_threshold_mv = sec_mv;

endmodule : ccc_chan_cfg
`default_nettype wire

// ===== src/ccc_pkg.sv
// Shared constants for the per-channel clock and coding configuration block
package ccc_pkg;

	// Channel count and register widths
	localparam int NCH = 4;
	localparam int CFG_W = 9;
	localparam int THR_W = 9;

	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CFG0 = 8'h00;
	localparam logic [7:0] OFS_CFG1 = 8'h04;
	localparam logic [7:0] OFS_CFG2 = 8'h08;
	localparam logic [7:0] OFS_CFG3 = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Field positions inside a channel configuration register
	localparam int F_RX_SRC = 0;
	localparam int F_RX_RATE = 1;
	localparam int F_PRI_LO = 2;
	localparam int F_SEC_LO = 4;
	localparam int F_ENC = 6;
	localparam int F_TX_SEL = 7;
	localparam int F_TX_RATE = 8;

	// Field positions inside one channel's nibble of the status register
	localparam int ST_W = 4;
	localparam int ST_DIVIDE = 0;
	localparam int ST_RXCLK = 1;
	localparam int ST_REF_HALF = 2;
	localparam int ST_TX_SEL = 3;

	// Reset value: source 1, rate 1, both detectors 10, encoder 1, tx clock 1, pll rate 0
	localparam logic [CFG_W-1:0] CFG_RESET = 9'h0eb;

	// Detector amplitude codes
	localparam logic [1:0] DET_OFF = 2'h0;
	localparam logic [1:0] DET_LOW = 2'h1;
	localparam logic [1:0] DET_MID = 2'h2;
	localparam logic [1:0] DET_HIGH = 2'h3;

	// Typical peak-to-peak differential thresholds in millivolts
	localparam logic [THR_W-1:0] THR_LOW_MV = 9'h08c;
	localparam logic [THR_W-1:0] THR_MID_MV = 9'h118;
	localparam logic [THR_W-1:0] THR_HIGH_MV = 9'h1a4;

	// Character widths
	localparam int TXD_W = 8;
	localparam int TXC_W = 2;
	localparam int CHAR_W = 10;

endpackage : ccc_pkg

// ===== src/ccc_sync_if.sv
// Synchronised levels and edge strobes passed from the sampler to the main block
`timescale 1ns/10ps
`default_nettype none
interface ccc_sync_if #(parameter int W = 1);
	logic [W-1:0] level; // Level after two flip-flops
	logic [W-1:0] rise; // One-cycle strobe on a low-to-high change
	logic [W-1:0] fall; // One-cycle strobe on a high-to-low change
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : ccc_sync_if
`default_nettype wire

// ===== src/ccc_link_sync.sv
// Two-flop synchroniser with edge detection for pins from outside clk_sys
`timescale 1ns/10ps
`default_nettype none
module ccc_link_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	ccc_sync_if.src o
);
	logic [W-1:0] stage1; // First stage, read only by stage2
	logic [W-1:0] stage2; // Settled level
	logic [W-1:0] stage3; // Previous settled level, for edges
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_stage2;
	logic [W-1:0] next_stage3;

	// Shift chain next values
	always_comb begin
		next_stage1 = d;
		next_stage2 = stage1;
		next_stage3 = stage2;
	end

	// Register the chain; reset to a known low level
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
			stage3 <= next_stage3;
		end
	end

	// Edges compare settled stages only, never the first stage
	assign o.level = stage2;
	assign o.rise = stage2 & ~stage3;
	assign o.fall = ~stage2 & stage3;

endmodule : ccc_link_sync
`default_nettype wire

// ===== testbench/ccc_chan_cfg_asserts.sv
// Port-level checks for the clock and coding configuration block
`timescale 1ns/10ps
`default_nettype none
module ccc_chan_cfg_asserts #(
	parameter int NCH = ccc_pkg::NCH
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [NCH-1:0] channel_reference_clock,
	input wire logic [NCH-1:0] tx_host_input_clock,
	input wire logic [NCH-1:0] rx_clock_out_pair_p,
	input wire logic [NCH-1:0] rx_clock_out_pair_n,
	input wire logic [NCH-1:0] tx_char_valid,
	input wire logic [NCH-1:0] tx_phase_align_bypass,
	input wire logic [NCH-1:0] primary_detect_enable,
	input wire logic [NCH-1:0][ccc_pkg::THR_W-1:0] primary_detect_threshold_mv,
	input wire logic [NCH-1:0] secondary_detect_enable,
	input wire logic [NCH-1:0][ccc_pkg::THR_W-1:0] secondary_detect_threshold_mv
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Bus answers exactly one cycle after a request is taken
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Request not answered");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Answer held too long");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("Read data outside answer");
	// Per-channel checks, one copy each
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		a_pair_compl: assert property (rx_clock_out_pair_p[c] != rx_clock_out_pair_n[c])
			else $error("Receive pair not complementary");
		a_pri_code: assert property (primary_detect_enable[c] ==
			(primary_detect_threshold_mv[c] != 0) &&
			primary_detect_threshold_mv[c] inside {9'h0, 9'h08c, 9'h118, 9'h1a4})
			else $error("Primary detector setting wrong");
		a_sec_code: assert property (secondary_detect_enable[c] ==
			(secondary_detect_threshold_mv[c] != 0) &&
			secondary_detect_threshold_mv[c] inside {9'h0, 9'h08c, 9'h118, 9'h1a4})
			else $error("Secondary detector setting wrong");
		a_valid_pulse: assert property (tx_char_valid[c] |=> !tx_char_valid[c])
			else $error("Capture strobe too long");
		// A capture needs an edge of the selected clock a few cycles earlier
		a_valid_cause: assert property (tx_char_valid[c] |-> (tx_phase_align_bypass[c] ?
			$past(channel_reference_clock[c], 2) != $past(channel_reference_clock[c], 5) :
			$past(tx_host_input_clock[c], 2) != $past(tx_host_input_clock[c], 5)))
			else $error("Capture without selected edge");
	end
endmodule : ccc_chan_cfg_asserts
bind ccc_chan_cfg ccc_chan_cfg_asserts #(.NCH(NCH)) chk_u (.clk_sys, .sys_rst, .wb_cyc_i,
	.wb_stb_i, .wb_dat_o, .wb_ack_o, .channel_reference_clock, .tx_host_input_clock,
	.rx_clock_out_pair_p, .rx_clock_out_pair_n, .tx_char_valid, .tx_phase_align_bypass,
	.primary_detect_enable, .primary_detect_threshold_mv, .secondary_detect_enable,
	.secondary_detect_threshold_mv);
`default_nettype wire

// ===== testbench/ccc_host_model.sv
// Host logic model: sends characters on its own clock, latches receive characters
`timescale 1ns/10ps
`default_nettype none
module ccc_host_model (
	input wire logic run,
	input wire logic alt,
	input wire logic rx_p,
	input wire logic rx_n,
	output logic tx_clk,
	output logic [ccc_pkg::CHAR_W-1:0] tx_char,
	output int latched
);
	int n_true; // Characters taken on rises of the true receive clock
	int n_compl; // Characters taken on complement rises, half-rate modes only
	// Clock parks low outside frames; data moves on the fall, far from the rise
	initial begin
		tx_clk = 1'b0;
		tx_char = 10'h155;
		#17.1;
		forever begin
			#32;
			tx_clk = run ? ~tx_clk : 1'b0;
			if (run && !tx_clk)
				tx_char = ~tx_char + 10'h0a7;
		end
	end
	// Half-rate modes latch alternately on the true and complement rises
	// One counter per process, so no variable has two writers
	always @(posedge rx_p) n_true <= n_true + 1;
	always @(posedge rx_n) if (alt) n_compl <= n_compl + 1;
	assign latched = n_true + n_compl;
endmodule : ccc_host_model
`default_nettype wire

// ===== testbench/ccc_chan_cfg_test.sv
// Self-checking bench for the clock and coding configuration block
`timescale 1ns/10ps
`default_nettype none
module ccc_chan_cfg_test;
	localparam int N = ccc_pkg::NCH;
	logic clk_sys, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, run, h_run, h_alt, h_clk;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, v;
	logic [N-1:0] channel_reference_clock, ref_clock_half_rate, recovered_byte_clock;
	logic [N-1:0] tx_host_input_clock, rx_clock_out_pair_p, rx_clock_out_pair_n, tx_char_valid;
	logic [N-1:0] tx_encoder_enable, tx_phase_align_bypass;
	logic [N-1:0] primary_detect_enable, secondary_detect_enable;
	logic [N-1:0][9:0] rx_char_in, rx_char_out, tx_char_out;
	logic [N-1:0][7:0] tx_char_data_in;
	logic [N-1:0][1:0] tx_char_control_in;
	logic [N-1:0][8:0] primary_detect_threshold_mv, secondary_detect_threshold_mv;
	logic [9:0] h_char, note_rec, note_ref; // Host transmit character, then characters the last receive load edges should take
	logic [1:0] txm; // Capture mode: 0 host, 1 reference rise, 2 both reference edges
	logic [2:0] mode; // Source, rate, half-rate reference
	logic [31:0] rd_q[$]; // Expected read data
	logic [9:0] tx_q[$]; // Expected captured characters
	logic [8:0] thr[4];
	int latched, base, want, n_ref, n_rec, err_total, n_tests, seed;
	assign tx_host_input_clock = {N{h_clk}};
	assign tx_char_data_in = {N{h_char[7:0]}};
	assign tx_char_control_in = {N{h_char[9:8]}};
	ccc_chan_cfg dut_u (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .channel_reference_clock, .ref_clock_half_rate,
		.recovered_byte_clock, .tx_host_input_clock, .rx_char_in, .tx_char_data_in,
		.tx_char_control_in, .rx_clock_out_pair_p, .rx_clock_out_pair_n, .rx_char_out,
		.tx_char_out, .tx_char_valid, .tx_encoder_enable, .tx_phase_align_bypass,
		.primary_detect_enable, .primary_detect_threshold_mv, .secondary_detect_enable,
		.secondary_detect_threshold_mv);
	ccc_host_model host_u (.run(h_run), .alt(h_alt), .rx_p(rx_clock_out_pair_p[0]),
		.rx_n(rx_clock_out_pair_n[0]), .tx_clk(h_clk), .tx_char(h_char), .latched);
	// Clocks; link clocks sit off the system grid and park low between frames
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		channel_reference_clock = '0;
		#5.3;
		forever #32 channel_reference_clock <= run ? ~channel_reference_clock : '0;
	end
	initial begin
		recovered_byte_clock = '0;
		#9.7;
		forever #48 recovered_byte_clock <= run ? ~recovered_byte_clock : '0;
	end
	always @(posedge channel_reference_clock[0]) n_ref++;
	always @(posedge recovered_byte_clock[0]) n_rec++;
	// Receive characters move on the fall, so every load edge takes a settled value
	always @(negedge recovered_byte_clock[0])
		if (run) rx_char_in <= 40'({$random(seed), $random(seed)});
	// Note what the output register should hold after each possible load edge
	always @(posedge recovered_byte_clock[0]) note_rec <= rx_char_in[0];
	always @(channel_reference_clock[0])
		if (channel_reference_clock[0] || mode[0]) note_ref <= rx_char_in[0];
	// Note what each capturing edge should take
	always @(posedge h_clk) if (txm == 2'h0) tx_q.push_back(h_char);
	always @(channel_reference_clock[0])
		if (txm == 2'h2 || (txm == 2'h1 && channel_reference_clock[0])) tx_q.push_back(h_char);
	// Results against the oldest note
	always @(posedge clk_sys) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check(wb_dat_o, rd_q.pop_front());
		if (tx_char_valid[0] === 1'b1)
			check(32'(tx_char_out[0]), 32'(tx_q.pop_front()));
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		$display("TB: err_total=%0d n_tests=%0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	// Classic single cycle; held until the answer is seen
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= 4'hf;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_sys);
		while (wb_ack_o !== 1'b1) @(posedge clk_sys);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic frame(input logic hr);
		h_run = hr;
		run = 1'b1;
		#1536;
		run = 1'b0;
		h_run = 1'b0;
		repeat (40) @(posedge clk_sys);
	endtask : frame
	initial begin
		#100000;
		err_total++;
		close_out();
	end
	initial begin
		{seed, sys_rst, run, h_run, h_alt, txm} = {32'd67419, 6'h21};
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {15'h000f, 32'h0};
		{ref_clock_half_rate, rx_char_in} = '0;
		thr = '{9'h000, 9'h08c, 9'h118, 9'h1a4};
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		for (int c = 0; c < N; c++) begin
			rd(8'(4 * c), 32'h0eb);
		end
		rd(8'h20, 32'h0);
		// Idle status: divide on, pair low, full-rate reference, reference capture
		rd(ccc_pkg::OFS_STATUS, 32'h9999);
		check(32'({tx_encoder_enable, tx_phase_align_bypass}), 32'hff);
		// Every detector code on channel 1, random bits beyond the fields
		for (int k = 0; k < 4; k++) begin
			v = $random(seed);
			v[8:2] = {1'b0, 2'(k), 2'(3 - k), 2'(k)};
			bus(1'b1, 8'h04, v);
			check(32'({primary_detect_enable[1], primary_detect_threshold_mv[1]}),
				32'({k != 0, thr[k]}));
			check(32'({secondary_detect_enable[1], secondary_detect_threshold_mv[1]}),
				32'({k != 3, thr[3 - k]}));
			check(32'({tx_encoder_enable[1:0], tx_phase_align_bypass[1:0]}),
				32'({k[0], 1'b1, k[1], 1'b1}));
			rd(8'h04, v & 32'h1ff);
		end
		// Receive clock modes, counted by what the host latches
		for (int m = 0; m < 5; m++) begin
			// Last mode keeps the rate bit set, which a half-rate reference must ignore
			mode = m[2] ? 3'b111 : (m[1] ? {~m[0], 2'b10} : {~m[0], 2'b00}) ^ 3'b010;
			ref_clock_half_rate <= {N{mode[0]}};
			h_alt <= mode[1] | (mode[2] & mode[0]);
			bus(1'b1, 8'h00, {23'h0, 9'h0e8 | {7'h0, mode[1], mode[2]}});
			{base, n_ref, n_rec} = {latched, 64'h0};
			frame(1'b0);
			want = mode[2] ? (mode[0] ? 2 * n_ref : n_ref) : n_rec;
			check(32'((latched - base - want) inside {[-1:1]}), 32'h1);
			check(32'(rx_char_out[0]), 32'(mode[2] ? note_ref : note_rec));
		end
		// Host clock, then reference rise, then both reference edges
		for (int t = 0; t < 3; t++) begin
			txm = 2'(t);
			bus(1'b1, 8'h00, (t == 0) ? 32'h06b : ((t == 1) ? 32'h0eb : 32'h1eb));
			frame(t == 0);
			check(32'(tx_q.size()), 32'h0);
		end
		close_out();
	end
endmodule : ccc_chan_cfg_test
`default_nettype wire
